// ---- logic/scc_cfg.svh ----
// Register map, field positions, reset values and timing figures of the capture/compare channel
// Contract
// - Frozen mode keeps the reference level
// - Modes 001/010 set high/low on match
// - Mode 011 toggles reference on every match
// - Modes 100/101 force reference low/high
// - PWM one: high while counter below compare
// - PWM two: low while counter below compare
// - PWM follows comparison, also leaving frozen mode
// - Preload off: compare writes act at once
// - Preload on: copy moves on update event
// - Trigger: slow path five cycles, fast three
// - Direction 00 output, 01 input one
// - Direction writes ignored while channel enabled
// - Filter code picks sample rate and count
// - Capture divider: every 1, 2, 4, 8 edges
// - Edge divider cleared while channel disabled
// - Polarity bit inverts reference onto pin
// - Polarity pair selects rising, falling or both
// - Disabled output drives 0, enable released
// - Enable bit gates captures in input mode
// - Prescaler divides by value plus one, loads on update
// - Capture copies counter into compare register
// - Capture sets flag; set flag marks overcapture
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// Byte addresses of the registers
`define SCC_OFS_CTRL    8'h00
`define SCC_OFS_STATUS  8'h10
`define SCC_OFS_EVGEN   8'h14
`define SCC_OFS_MODE    8'h18
`define SCC_OFS_ENPOL   8'h20
`define SCC_OFS_COUNT   8'h24
`define SCC_OFS_PRESC   8'h28
`define SCC_OFS_CMP     8'h34

// Control register fields
`define SCC_CTRL_RUN_BIT    0
`define SCC_CTRL_DTS_LSB    8
`define SCC_CTRL_DTS_MSB    9
// Status register fields
`define SCC_ST_CAP_BIT      1
`define SCC_ST_OVR_BIT      9
// Event generation fields
`define SCC_EV_UPD_BIT      0
`define SCC_EV_CAP_BIT      1
// Enable and polarity fields
`define SCC_EP_EN_BIT       0
`define SCC_EP_POL_BIT      1
`define SCC_EP_NPOL_BIT     3

// Reset values and counter top value
`define SCC_RST_16          16'h0000
`define SCC_RST_8           8'h00
`define SCC_CNT_TOP         16'hFFFF

// Direction codes
`define SCC_DIR_OUT         2'h0
`define SCC_DIR_IN          2'h1

// Polarity pair codes {complementary, polarity}
`define SCC_EDGE_RISE       2'h0
`define SCC_EDGE_FALL       2'h1
`define SCC_EDGE_BOTH       2'h3

// AXI response codes
`define SCC_RESP_OKAY       2'h0
`define SCC_RESP_SLVERR     2'h2

// Trigger to pin latency in clock cycles
`define SCC_TRIG_SLOW_CYC   5
`define SCC_TRIG_FAST_CYC   3

`endif

// ---- logic/scc_pkg.sv ----
// Types shared by the capture/compare channel
package scc_pkg;

  // Reference waveform modes
  typedef enum logic [2:0] {
    SCC_FROZEN   = 3'h0,
    SCC_SET_HI   = 3'h1,
    SCC_SET_LO   = 3'h2,
    SCC_TOGGLE   = 3'h3,
    SCC_FORCE_LO = 3'h4,
    SCC_FORCE_HI = 3'h5,
    SCC_PWM_ONE  = 3'h6,
    SCC_PWM_TWO  = 3'h7
  } scc_mode_type;

  // Mode register viewed for output use
  typedef struct packed {
    logic         rsv;
    scc_mode_type out_mode_sel;
    logic         compare_preload_en;
    logic         fast_trigger_en;
    logic [1:0]   direction_sel;
  } scc_out_cfg_type;

  // Mode register viewed for input use
  typedef struct packed {
    logic [3:0] input_filter_sel;
    logic [1:0] capture_divider;
    logic [1:0] direction_sel;
  } scc_in_cfg_type;

  // Enable and polarity bits
  typedef struct packed {
    logic complementary_polarity;
    logic chan_polarity;
    logic chan_enable;
  } scc_enpol_type;

  // Filter setting: sample divider and sample count
  typedef struct packed {
    logic [7:0] div;
    logic [3:0] num;
  } scc_filt_type;

endpackage

// ---- logic/scc_top.sv ----
// Single capture/compare channel with counter, prescaler and AXI4-Lite registers
`timescale 1ns/10ps
`include "scc_cfg.svh"

module scc_top #(
  parameter int FILT_DIV_W = 8  // Width of the filter sample divider
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // AXI4-Lite write address
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  // AXI4-Lite write data
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  // AXI4-Lite read address
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Channel pins
  input  wire logic        TIMER_INPUT_ONE_I,
  input  wire logic        TRIGGER_I,
  output logic             CHAN_OUT_PIN_O,
  output logic             OUTPUT_DRIVE_EN_N_O
);

  // Elaboration check of the divider width
  if (FILT_DIV_W < 8) begin : g_chk
    $error("FILT_DIV_W must be at least 8");
  end

  // Register state
  logic [7:0]              mode_ff;        // Raw mode register
  scc_pkg::scc_enpol_type  enpol_ff;       // Enable and polarity
  logic                    run_ff;         // Counter running
  logic [1:0]              dts_ff;         // Dead sample rate divider code
  logic [15:0]             cnt_ff;         // Counter value
  logic [15:0]             psc_pre_ff;     // Prescaler preload
  logic [15:0]             psc_act_ff;     // Active prescaler
  logic [15:0]             psc_div_ff;     // Prescaler counter
  logic [15:0]             cmp_pre_ff;     // Compare preload copy
  logic [15:0]             cmp_act_ff;     // Active compare value
  logic                    cap_flag_ff;    // Capture flag
  logic                    ovr_flag_ff;    // Overcapture flag
  logic                    ref_ff;         // Reference waveform
  // Bus state
  logic                    aw_hold_ff;     // Write address held
  logic [7:0]              aw_addr_ff;     // Held write address
  logic                    w_hold_ff;      // Write data held
  logic [31:0]             w_data_ff;      // Held write data
  logic [3:0]              w_strb_ff;      // Held byte strobes
  logic                    bvalid_ff;      // Response pending
  logic [1:0]              bresp_ff;       // Write response code
  logic                    rvalid_ff;      // Read data pending
  logic [31:0]             rdata_ff;       // Read data
  logic [1:0]              rresp_ff;       // Read response code
  // Pin state
  logic                    pin_ff;         // Output pin level
  logic                    oe_n_ff;        // Output enable, low drives
  logic [1:0]              ti_sync_ff;     // Input synchroniser
  logic [1:0]              tr_sync_ff;     // Trigger synchroniser
  logic                    tr_d_ff;        // Trigger last level
  logic                    tr_evt_ff;      // Trigger edge, slow path
  logic [FILT_DIV_W-1:0]   smp_cnt_ff;     // Filter sample divider
  logic [3:0]              flt_cnt_ff;     // Consecutive sample count
  logic                    flt_ff;         // Filtered input
  logic                    flt_d_ff;       // Filtered input last level
  logic [2:0]              edge_cnt_ff;    // Capture edge divider

  // Decoded views and events
  scc_pkg::scc_out_cfg_type oc;            // Output view of mode register
  scc_pkg::scc_in_cfg_type  ic;            // Input view of mode register
  scc_pkg::scc_filt_type    fset;          // Filter setting
  logic        do_wr;                      // Write performed this cycle
  logic        do_rd;                      // Read taken this cycle
  logic [15:0] wd16;                       // Low half of write data
  logic [1:0]  ws2;                        // Low strobes
  logic        wr_ctrl, wr_st, wr_ev, wr_mode, wr_ep, wr_cnt, wr_psc, wr_cmp;
  logic        is_out, is_in;              // Direction decode
  logic        tick;                       // Counter tick
  logic        upd;                        // Update event
  logic        ug;                         // Software update request
  logic        sw_cap;                     // Software capture request
  logic        tr_edge;                    // Trigger edge, fast path
  logic        match, below;               // Comparison results
  logic        nxt_ref;                    // Next reference level
  logic        edge_ok;                    // Valid input edge
  logic        capture;                    // Capture this cycle
  logic        rd_cmp;                     // Compare register read
  logic        addr_ok_w;                  // Write address mapped
  logic [2:0]  edge_last;                  // Edge divider terminal value
  logic [15:0] rd_mux;                     // Read data selection
  logic        rd_ok;                      // Read address mapped

  assign oc = scc_pkg::scc_out_cfg_type'(mode_ff);
  assign ic = scc_pkg::scc_in_cfg_type'(mode_ff);
  assign is_out = oc.direction_sel == `SCC_DIR_OUT;
  assign is_in  = oc.direction_sel == `SCC_DIR_IN;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Filter table: divider in clock cycles and sample count
  function automatic scc_pkg::scc_filt_type filt_lookup(input logic [3:0] code,
                                                        input logic [1:0] dts);
    logic [7:0] base;
    base = 8'h01 << dts;
    filt_lookup.num = 4'h8;
    unique case (code)
      4'h0: begin filt_lookup.div = base;       filt_lookup.num = 4'h1; end
      4'h1: begin filt_lookup.div = 8'h01;      filt_lookup.num = 4'h2; end
      4'h2: begin filt_lookup.div = 8'h01;      filt_lookup.num = 4'h4; end
      4'h3: begin filt_lookup.div = 8'h01;      filt_lookup.num = 4'h8; end
      4'h4: begin filt_lookup.div = base << 1;  filt_lookup.num = 4'h6; end
      4'h5: begin filt_lookup.div = base << 1;  filt_lookup.num = 4'h8; end
      4'h6: begin filt_lookup.div = base << 2;  filt_lookup.num = 4'h6; end
      4'h7: begin filt_lookup.div = base << 2;  filt_lookup.num = 4'h8; end
      4'h8: begin filt_lookup.div = base << 3;  filt_lookup.num = 4'h6; end
      4'h9: begin filt_lookup.div = base << 3;  filt_lookup.num = 4'h8; end
      4'hA: begin filt_lookup.div = base << 4;  filt_lookup.num = 4'h5; end
      4'hB: begin filt_lookup.div = base << 4;  filt_lookup.num = 4'h6; end
      4'hC: begin filt_lookup.div = base << 4;  filt_lookup.num = 4'h8; end
      4'hD: begin filt_lookup.div = base << 5;  filt_lookup.num = 4'h5; end
      4'hE: begin filt_lookup.div = base << 5;  filt_lookup.num = 4'h6; end
      4'hF: begin filt_lookup.div = base << 5;  filt_lookup.num = 4'h8; end
    endcase
  endfunction

  // ---- AXI4-Lite slave ----
  assign AWREADY_O = !aw_hold_ff && !bvalid_ff;
  assign WREADY_O  = !w_hold_ff && !bvalid_ff;
  assign ARREADY_O = !rvalid_ff;
  assign BVALID_O  = bvalid_ff;
  assign BRESP_O   = bresp_ff;
  assign RVALID_O  = rvalid_ff;
  assign RDATA_O   = rdata_ff;
  assign RRESP_O   = rresp_ff;

  assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign do_rd = ARVALID_I && !rvalid_ff;
  assign wd16  = w_data_ff[15:0];
  assign ws2   = w_strb_ff[1:0];
  assign wr_ctrl = do_wr && aw_addr_ff == `SCC_OFS_CTRL;
  assign wr_st   = do_wr && aw_addr_ff == `SCC_OFS_STATUS;
  assign wr_ev   = do_wr && aw_addr_ff == `SCC_OFS_EVGEN;
  assign wr_mode = do_wr && aw_addr_ff == `SCC_OFS_MODE;
  assign wr_ep   = do_wr && aw_addr_ff == `SCC_OFS_ENPOL;
  assign wr_cnt  = do_wr && aw_addr_ff == `SCC_OFS_COUNT;
  assign wr_psc  = do_wr && aw_addr_ff == `SCC_OFS_PRESC;
  assign wr_cmp  = do_wr && aw_addr_ff == `SCC_OFS_CMP;
  assign addr_ok_w = wr_ctrl | wr_st | wr_ev | wr_mode | wr_ep | wr_cnt | wr_psc | wr_cmp;

  // Address and data capture, taken in either order
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= `SCC_RST_8;
      w_hold_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= {AWADDR_I[7:2], 2'h0};
      end else if (do_wr) begin
        aw_hold_ff <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= WDATA_I;
        w_strb_ff <= WSTRB_I;
      end else if (do_wr) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped address
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SCC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= addr_ok_w ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
    end else if (BREADY_I) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = `SCC_RST_16;
    unique case ({ARADDR_I[7:2], 2'h0})
      `SCC_OFS_CTRL:   begin
        rd_mux[`SCC_CTRL_RUN_BIT] = run_ff;
        rd_mux[`SCC_CTRL_DTS_MSB:`SCC_CTRL_DTS_LSB] = dts_ff;
      end
      `SCC_OFS_STATUS: begin
        rd_mux[`SCC_ST_CAP_BIT] = cap_flag_ff;
        rd_mux[`SCC_ST_OVR_BIT] = ovr_flag_ff;
      end
      `SCC_OFS_EVGEN:  rd_mux = `SCC_RST_16;
      `SCC_OFS_MODE:   rd_mux = {8'h00, mode_ff};
      `SCC_OFS_ENPOL:  begin
        rd_mux[`SCC_EP_EN_BIT]   = enpol_ff.chan_enable;
        rd_mux[`SCC_EP_POL_BIT]  = enpol_ff.chan_polarity;
        rd_mux[`SCC_EP_NPOL_BIT] = enpol_ff.complementary_polarity;
      end
      `SCC_OFS_COUNT:  rd_mux = cnt_ff;
      `SCC_OFS_PRESC:  rd_mux = psc_pre_ff;
      `SCC_OFS_CMP:    rd_mux = cmp_pre_ff;
      default:         rd_ok  = 1'b0;
    endcase
  end
  assign rd_cmp = do_rd && {ARADDR_I[7:2], 2'h0} == `SCC_OFS_CMP;

  // Read answer, held until the master takes it
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `SCC_RESP_OKAY;
    end else if (do_rd) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {16'h0000, rd_mux};
      rresp_ff  <= rd_ok ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
    end else if (RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---- Configuration registers ----
  assign ug     = wr_ev && ws2[0] && wd16[`SCC_EV_UPD_BIT];
  assign sw_cap = wr_ev && ws2[0] && wd16[`SCC_EV_CAP_BIT];

  // Control, mode and enable registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      run_ff   <= 1'b0;
      dts_ff   <= 2'h0;
      mode_ff  <= `SCC_RST_8;
      enpol_ff <= '0;
    end else begin
      if (wr_ctrl && ws2[0]) run_ff <= wd16[`SCC_CTRL_RUN_BIT];
      if (wr_ctrl && ws2[1]) dts_ff <= wd16[`SCC_CTRL_DTS_MSB:`SCC_CTRL_DTS_LSB];
      if (wr_mode && ws2[0]) begin
        mode_ff[7:2] <= wd16[7:2];
        if (!enpol_ff.chan_enable) mode_ff[1:0] <= wd16[1:0];
      end
      if (wr_ep && ws2[0]) begin
        enpol_ff.chan_enable            <= wd16[`SCC_EP_EN_BIT];
        enpol_ff.chan_polarity          <= wd16[`SCC_EP_POL_BIT];
        enpol_ff.complementary_polarity <= wd16[`SCC_EP_NPOL_BIT];
      end
    end
  end

  // ---- Time base ----
  assign tick = psc_div_ff == psc_act_ff;
  assign upd  = ug || tr_evt_ff || (run_ff && tick && cnt_ff == `SCC_CNT_TOP);

  // Prescaler counter and active prescaler
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      psc_pre_ff <= `SCC_RST_16;
      psc_act_ff <= `SCC_RST_16;
      psc_div_ff <= `SCC_RST_16;
    end else begin
      if (wr_psc) psc_pre_ff <= merge16(psc_pre_ff, wd16, ws2);
      if (upd) psc_act_ff <= psc_pre_ff;
      if (ug || tr_evt_ff || tick) psc_div_ff <= `SCC_RST_16;
      else if (run_ff) psc_div_ff <= psc_div_ff + 16'h0001;
    end
  end

  // Counter: cleared by update request or slow trigger path
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_ff <= `SCC_RST_16;
    end else if (ug || tr_evt_ff) begin
      cnt_ff <= `SCC_RST_16;
    end else if (wr_cnt) begin
      cnt_ff <= merge16(cnt_ff, wd16, ws2);
    end else if (run_ff && tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // ---- Trigger input ----
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tr_sync_ff <= 2'h0;
      tr_d_ff    <= 1'b0;
      tr_evt_ff  <= 1'b0;
    end else begin
      tr_sync_ff <= {tr_sync_ff[0], TRIGGER_I};
      tr_d_ff    <= tr_sync_ff[1];
      tr_evt_ff  <= tr_edge;
    end
  end
  assign tr_edge = tr_sync_ff[1] && !tr_d_ff;

  // ---- Compare register ----
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmp_pre_ff <= `SCC_RST_16;
      cmp_act_ff <= `SCC_RST_16;
    end else if (capture) begin
      cmp_pre_ff <= cnt_ff;
      cmp_act_ff <= cnt_ff;
    end else if (wr_cmp) begin
      cmp_pre_ff <= merge16(cmp_pre_ff, wd16, ws2);
      if (!oc.compare_preload_en) cmp_act_ff <= merge16(cmp_pre_ff, wd16, ws2);
    end else if (upd && oc.compare_preload_en) begin
      cmp_act_ff <= cmp_pre_ff;
    end
  end

  // ---- Reference waveform ----
  assign match = cnt_ff == cmp_act_ff;
  assign below = cnt_ff < cmp_act_ff;

  // Next reference level by mode
  always_comb begin
    nxt_ref = ref_ff;
    unique case (oc.out_mode_sel)
      scc_pkg::SCC_FROZEN:   nxt_ref = ref_ff;
      scc_pkg::SCC_SET_HI:   if (match) nxt_ref = 1'b1;
      scc_pkg::SCC_SET_LO:   if (match) nxt_ref = 1'b0;
      scc_pkg::SCC_TOGGLE:   if (match) nxt_ref = !ref_ff;
      scc_pkg::SCC_FORCE_LO: nxt_ref = 1'b0;
      scc_pkg::SCC_FORCE_HI: nxt_ref = 1'b1;
      scc_pkg::SCC_PWM_ONE:  nxt_ref = (oc.fast_trigger_en && tr_edge) ? 1'b0 : below;
      scc_pkg::SCC_PWM_TWO:  nxt_ref = (oc.fast_trigger_en && tr_edge) ? 1'b1 : !below;
    endcase
  end

  // Reference and pin registers; pin follows next level for the fast path
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ref_ff  <= 1'b0;
      pin_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      ref_ff <= nxt_ref;
      if (is_out && enpol_ff.chan_enable) begin
        pin_ff  <= nxt_ref ^ enpol_ff.chan_polarity;
        oe_n_ff <= 1'b0;
      end else begin
        pin_ff  <= 1'b0;
        oe_n_ff <= 1'b1;
      end
    end
  end
  assign CHAN_OUT_PIN_O      = pin_ff;
  assign OUTPUT_DRIVE_EN_N_O = oe_n_ff;

  // ---- Input filter ----
  assign fset = filt_lookup(ic.input_filter_sel, dts_ff);

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ti_sync_ff <= 2'h0;
      smp_cnt_ff <= '0;
      flt_cnt_ff <= 4'h0;
      flt_ff     <= 1'b0;
      flt_d_ff   <= 1'b0;
    end else begin
      ti_sync_ff <= {ti_sync_ff[0], TIMER_INPUT_ONE_I};
      flt_d_ff   <= flt_ff;
      if (smp_cnt_ff >= FILT_DIV_W'(fset.div - 8'h01)) begin
        smp_cnt_ff <= '0;
        if (ti_sync_ff[1] == flt_ff) begin
          flt_cnt_ff <= 4'h0;
        end else if (flt_cnt_ff + 4'h1 >= fset.num) begin
          flt_ff     <= ti_sync_ff[1];
          flt_cnt_ff <= 4'h0;
        end else begin
          flt_cnt_ff <= flt_cnt_ff + 4'h1;
        end
      end else begin
        smp_cnt_ff <= smp_cnt_ff + FILT_DIV_W'(1);
      end
    end
  end

  // ---- Edge selection and capture divider ----
  always_comb begin
    unique case ({enpol_ff.complementary_polarity, enpol_ff.chan_polarity})
      `SCC_EDGE_FALL: edge_ok = !flt_ff && flt_d_ff;
      `SCC_EDGE_BOTH: edge_ok = flt_ff != flt_d_ff;
      default:        edge_ok = flt_ff && !flt_d_ff;
    endcase
  end
  assign edge_last = (3'h1 << ic.capture_divider) - 3'h1;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      edge_cnt_ff <= 3'h0;
    end else if (!enpol_ff.chan_enable) begin
      edge_cnt_ff <= 3'h0;
    end else if (is_in && edge_ok) begin
      edge_cnt_ff <= (edge_cnt_ff >= edge_last) ? 3'h0 : edge_cnt_ff + 3'h1;
    end
  end

  assign capture = is_in && enpol_ff.chan_enable &&
                   ((edge_ok && edge_cnt_ff >= edge_last) || sw_cap);

  // ---- Flags: a set wins over a clear in the same cycle ----
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cap_flag_ff <= 1'b0;
      ovr_flag_ff <= 1'b0;
    end else begin
      if (capture || (is_out && (match || sw_cap))) cap_flag_ff <= 1'b1;
      else if (rd_cmp && is_in) cap_flag_ff <= 1'b0;
      else if (wr_st && ws2[0] && !wd16[`SCC_ST_CAP_BIT]) cap_flag_ff <= 1'b0;
      if (capture && cap_flag_ff) ovr_flag_ff <= 1'b1;
      else if (wr_st && ws2[1] && !wd16[`SCC_ST_OVR_BIT]) ovr_flag_ff <= 1'b0;
    end
  end

endmodule

// ---- bench/scc_pins_model.sv ----
// Pin driver outside the channel
`timescale 1ns/10ps
module scc_pins_model (
  input  wire logic CLK_I,             // Timer clock
  output logic      TIMER_INPUT_ONE_I, // Input pin
  output logic      TRIGGER_I          // Trigger pin, idle
);
  initial begin
    TIMER_INPUT_ONE_I = 1'b0;
    TRIGGER_I         = 1'b0;
  end
  // Pulse long enough to pass sync and filter
  task automatic pulse();
    @(posedge CLK_I) TIMER_INPUT_ONE_I <= 1'b1;
    repeat (8) @(posedge CLK_I);
    TIMER_INPUT_ONE_I <= 1'b0;
    repeat (8) @(posedge CLK_I);
  endtask
  // Trigger rising edge, then time to reach the pin
  task automatic trig();
    @(posedge CLK_I) TRIGGER_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    TRIGGER_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
  endtask
endmodule

// ---- bench/scc_top_properties.sv ----
// Bus and pin checks of the channel
`timescale 1ns/10ps
module scc_top_properties (
  input wire logic        CLK_I, NRST_I, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O,
  input wire logic        BVALID_O, BREADY_I, ARVALID_I, ARREADY_O, RVALID_O, RREADY_I,
  input wire logic        CHAN_OUT_PIN_O, OUTPUT_DRIVE_EN_N_O,
  input wire logic [1:0]  BRESP_O,
  input wire logic [31:0] RDATA_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_bvalid_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write answer dropped");
  a_bvalid_drop: assert property (BVALID_O && BREADY_I |=> !BVALID_O) else $error("b stuck");
  a_rvalid_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read answer dropped");
  a_write_block: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O) else $error("aw open");
  a_read_block: assert property (RVALID_O |-> !ARREADY_O) else $error("ar open");
  a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O) else $error("r late");
  a_write_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2
    BVALID_O) else $error("b late");
  a_rdata_upper: assert property (RVALID_O |-> RDATA_O[31:16] == 16'h0000) else $error("hi");
  a_drive_off: assert property (OUTPUT_DRIVE_EN_N_O |-> !CHAN_OUT_PIN_O)
    else $error("pin high while released");
endmodule
bind scc_top scc_top_properties i_chk (.*);

// ---- bench/scc_top_tb_top.sv ----
// Register and pin tests of the channel
`timescale 1ns/10ps
module scc_top_tb_top;
  logic CLK_I, NRST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, AWREADY_O;
  logic WREADY_O, BVALID_O, ARREADY_O, RVALID_O, CHAN_OUT_PIN_O, OUTPUT_DRIVE_EN_N_O;
  logic TIMER_INPUT_ONE_I, TRIGGER_I;
  logic [7:0]  AWADDR_I, ARADDR_I;
  logic [3:0]  WSTRB_I;
  logic [1:0]  BRESP_O, RRESP_O, rsp;
  logic [31:0] WDATA_I, RDATA_O, rdat;
  logic [7:0]  md [8] = '{8'h40, 8'h10, 8'h00, 8'h20, 8'h30, 8'h68, 8'h78, 8'h50};
  logic        ex [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int fails, check_count;
  scc_top i_dut (.*);
  scc_pins_model i_pins (.*);
  initial begin CLK_I = 0; forever #25 CLK_I = ~CLK_I; end
  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin fails++; $display("ERROR %0t got %h exp %h", $time, g, e); end
  endtask
  // Hang guard on every wait loop
  task automatic tick(inout int n);
    n++;
    if (n > 200) begin fails++; $display("ERROR %0t hang", $time); finish_test(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n; logic ta, tw;
    n = 0; ta = 0; tw = 0;
    AWADDR_I <= a; WDATA_I <= d; AWVALID_I <= 1'b1; WVALID_I <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge CLK_I); tick(n); ta = ta || AWREADY_O; tw = tw || WREADY_O;
      @(posedge CLK_I); if (ta) AWVALID_I <= 1'b0; if (tw) WVALID_I <= 1'b0;
    end
    BREADY_I <= 1'b1;
    do begin @(negedge CLK_I); tick(n); end while (BVALID_O !== 1'b1);
    chk({30'h0, BRESP_O}, {30'h0, r});
    @(posedge CLK_I) BREADY_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n; n = 0;
    ARADDR_I <= a; ARVALID_I <= 1'b1;
    do begin @(negedge CLK_I); tick(n); end while (ARREADY_O !== 1'b1);
    @(posedge CLK_I) ARVALID_I <= 1'b0; RREADY_I <= 1'b1;
    do begin @(negedge CLK_I); tick(n); end while (RVALID_O !== 1'b1);
    rdat = RDATA_O; rsp = RRESP_O;
    @(posedge CLK_I) RREADY_I <= 1'b0;
    chk(rdat, e); chk({30'h0, rsp}, {30'h0, r});
  endtask
  // Pin level and drive enable
  task automatic pc(input logic p, input logic q);
    repeat (2) @(negedge CLK_I);
    chk({30'h0, CHAN_OUT_PIN_O, OUTPUT_DRIVE_EN_N_O}, {30'h0, p, q});
    @(posedge CLK_I);
  endtask
  initial begin
    NRST_I = 0; AWVALID_I = 0; WVALID_I = 0; BREADY_I = 0; ARVALID_I = 0; RREADY_I = 0;
    AWADDR_I = 0; ARADDR_I = 0; WDATA_I = 0; WSTRB_I = 4'h3;
    repeat (6) @(posedge CLK_I);
    NRST_I <= 1'b1;
    @(posedge CLK_I);
    foreach (md[i]) if (i < 4) rd(8'h18 + 8'((i + (i > 0)) * 4), 32'h0, 2'h0); // Reset values
    rd(8'h3C, 32'h0, 2'h2); // Unmapped
    wr(8'h3C, 32'h1, 2'h2); // Unmapped
    pc(1'b0, 1'b1);
    $display("test registers done");
    wr(8'h34, 32'h20);
    wr(8'h20, 32'h1);
    wr(8'h00, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(8'h18, {24'h0, md[i]});
      wr(8'h24, 32'h0);
      repeat (60) @(posedge CLK_I);
      pc(ex[i], 1'b0);
    end
    wr(8'h18, 32'h68); i_pins.trig(); pc(1'b1, 1'b0);
    wr(8'h34, 32'h0); pc(1'b1, 1'b0); rd(8'h34, 32'h0, 2'h0);
    wr(8'h14, 32'h1); pc(1'b0, 1'b0);
    wr(8'h18, 32'h51); rd(8'h18, 32'h50, 2'h0);
    wr(8'h20, 32'h3); pc(1'b0, 1'b0);
    wr(8'h20, 32'h0); pc(1'b0, 1'b1);
    $display("test outputs done");
    wr(8'h18, 32'h01); wr(8'h20, 32'h1); wr(8'h10, 32'h0);
    i_pins.pulse(); rd(8'h10, 32'h2, 2'h0);
    i_pins.pulse(); rd(8'h10, 32'h202, 2'h0);
    wr(8'h18, 32'h05); wr(8'h10, 32'h0); i_pins.pulse(); rd(8'h10, 32'h0, 2'h0);
    i_pins.pulse(); rd(8'h10, 32'h2, 2'h0);
    wr(8'h10, 32'h0); wr(8'h20, 32'h0); i_pins.pulse(); rd(8'h10, 32'h0, 2'h0);
    $display("test capture done");
    finish_test();
  end
endmodule
